/* File: verilog/ofd_pkg.sv */
package ofd_pkg;

   // file addresses of the special registers
   localparam logic [7:0] SFR_PCL = 8'h02;
   localparam logic [7:0] SFR_PC_HIGH_HOLDING_LATCH = 8'h03;
   localparam logic [7:0] SFR_ALUF = 8'h04;
   localparam logic [7:0] SFR_CPUST = 8'h06;
   localparam logic [7:0] SFR_IFLAG = 8'h07;
   localparam logic [7:0] SFR_WORKING_REGISTER = 8'h0A;
   localparam logic [7:0] SFR_TBPL = 8'h0D;
   localparam logic [7:0] SFR_TBPH = 8'h0E;

   // wishbone byte offsets
   localparam logic [7:0] BA_INSTR = 8'h00;
   localparam logic [7:0] BA_WORKING_REGISTER = 8'h04;
   localparam logic [7:0] BA_ALUF = 8'h08;
   localparam logic [7:0] BA_PC = 8'h0C;
   localparam logic [7:0] BA_PC_HIGH_HOLDING_LATCH = 8'h10;
   localparam logic [7:0] BA_TBPTR = 8'h14;
   localparam logic [7:0] BA_TABLE_LATCH = 8'h18;
   localparam logic [7:0] BA_CPUST = 8'h1C;
   localparam logic [7:0] BA_IFLAG = 8'h20;

   // flag bit positions
   localparam int FLG_C = 0;
   localparam int FLG_DC = 1;
   localparam int FLG_Z = 2;
   localparam int FLG_OV = 3;
   localparam int GIM_BIT = 4;

   // values after reset
   localparam logic [7:0] CPUST_RST = 8'h10;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [15:0] WORD_RST = 16'h0000;

   typedef enum logic [1:0] {
      Q1 = 2'b00,
      Q2 = 2'b01,
      Q3 = 2'b10,
      Q4 = 2'b11
   } ofd_phase_t;

   typedef enum logic [3:0] {
      OP_NOP = 4'h0, OP_ADD = 4'h1, OP_SUB = 4'h2, OP_AND = 4'h3,
      OP_IOR = 4'h4, OP_XOR = 4'h5, OP_COM = 4'h6, OP_INC = 4'h7,
      OP_DEC = 4'h8, OP_MOVWF = 4'h9, OP_CLR = 4'hA, OP_SET = 4'hB,
      OP_MOVE = 4'hC, OP_BIT = 4'hD, OP_TLRD = 4'hE, OP_TLWT = 4'hF
   } ofd_op_t;

   // decoded operand fields
   typedef struct packed {
      ofd_op_t op;
      logic [7:0] src;
      logic [7:0] dst;
      logic wr_f;
      logic wr_w;
      logic tlw;
      logic [2:0] bnum;
      logic [1:0] bop;
      logic hi;
      logic inc;
   } ofd_dec_t;

   // addresses held in flops rather than the file memory
   function automatic logic ofd_is_sfr(input logic [7:0] a);
      return a inside {SFR_PCL, SFR_PC_HIGH_HOLDING_LATCH, SFR_ALUF, SFR_CPUST, SFR_IFLAG,
                       SFR_WORKING_REGISTER, SFR_TBPL, SFR_TBPH};
   endfunction

   // field decode of one instruction word
   function automatic ofd_dec_t ofd_decode(input logic [15:0] iw);
      ofd_dec_t d;
      d = '0;
      d.op = OP_NOP;
      d.src = iw[7:0]; // RULE1
      d.dst = iw[7:0];
      d.bnum = iw[10:8]; // RULE9
      d.hi = iw[9];
      casez (iw[15:8])
         8'b0000_0001: d.op = OP_MOVWF;
         8'b0000_010?: d.op = OP_SUB;
         8'b0000_011?: d.op = OP_DEC;
         8'b0000_100?: d.op = OP_IOR;
         8'b0000_101?: d.op = OP_AND;
         8'b0000_110?: d.op = OP_XOR;
         8'b0000_111?: d.op = OP_ADD;
         8'b0001_001?: d.op = OP_COM;
         8'b0001_010?: d.op = OP_INC;
         8'b0010_100?: d.op = OP_CLR;
         8'b0010_101?: d.op = OP_SET;
         8'b010?_????: begin
            d.op = OP_MOVE;
            d.src = {3'b000, iw[12:8]}; // RULE2
         end
         8'b011?_????: begin
            d.op = OP_MOVE;
            d.dst = {3'b000, iw[12:8]}; // RULE2
         end
         8'b1000_????: begin
            d.op = OP_BIT;
            d.bop = {1'b0, iw[11]};
         end
         8'b0011_1???: begin
            d.op = OP_BIT;
            d.bop = 2'b10;
         end
         // bit 8 is a don't-care here
         8'b1010_0???: d.op = iw[10] ? OP_TLWT : OP_TLRD; // RULE7
         8'b1010_1???: begin
            d.op = iw[10] ? OP_TLWT : OP_TLRD;
            d.inc = iw[8]; // RULE3
         end
         default: d.op = OP_NOP; // RULE12
      endcase
      case (d.op)
         OP_SUB, OP_DEC, OP_IOR, OP_AND, OP_XOR, OP_ADD, OP_COM, OP_INC: begin
            d.wr_f = iw[8]; // RULE5
            d.wr_w = ~iw[8];
         end
         OP_CLR, OP_SET: begin
            d.wr_f = 1'b1; // RULE6
            d.wr_w = ~iw[8];
         end
         OP_MOVWF, OP_MOVE, OP_BIT, OP_TLRD: d.wr_f = 1'b1;
         OP_TLWT: d.tlw = 1'b1;
         default: d.wr_f = 1'b0;
      endcase
      return d;
   endfunction

endpackage

/* File: verilog/ofd_fmem.sv */
`timescale 1ns/10ps
// file register memory, read data registered
module ofd_fmem (
   input wire logic clk_i,
   input wire logic ce_i,
   input wire logic we_i,
   input wire logic [7:0] waddr_i,
   input wire logic [7:0] wdata_i,
   input wire logic [7:0] raddr_i,
   output logic [7:0] rdata_o
);
   logic [7:0] mem [0:255];

   // write port and registered read port
   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         if (we_i) begin
            mem[waddr_i] <= wdata_i;
         end
         rdata_o <= mem[raddr_i];
      end
   end
endmodule

/* File: verilog/ofd_alu.sv */
`timescale 1ns/10ps
// byte alu with flag results and flag update mask
module ofd_alu (
   input wire ofd_pkg::ofd_op_t op_i,
   input wire logic [7:0] a_i,
   input wire logic [7:0] w_i,
   input wire logic [2:0] bnum_i,
   input wire logic [1:0] bop_i,
   output logic [7:0] res_o,
   output logic [3:0] flg_o,
   output logic [3:0] fmask_o
);
   logic [7:0] b;
   logic ci;
   logic [8:0] s9;
   logic [4:0] h5;

   // adder operand selection
   always_comb begin
      b = w_i;
      ci = 1'b0;
      case (op_i)
         ofd_pkg::OP_SUB: begin
            b = ~w_i;
            ci = 1'b1;
         end
         ofd_pkg::OP_INC: begin
            b = 8'h00;
            ci = 1'b1;
         end
         ofd_pkg::OP_DEC: b = 8'hFF;
         default: b = w_i;
      endcase
      s9 = 9'({1'b0, a_i}) + 9'({1'b0, b}) + 9'({8'h00, ci});
      h5 = 5'({1'b0, a_i[3:0]}) + 5'({1'b0, b[3:0]}) + 5'({4'h0, ci});
   end

   // result and flags
   always_comb begin
      res_o = a_i;
      fmask_o = 4'h0;
      flg_o = 4'h0;
      case (op_i)
         ofd_pkg::OP_ADD, ofd_pkg::OP_SUB, ofd_pkg::OP_INC, ofd_pkg::OP_DEC: begin
            res_o = s9[7:0];
            fmask_o = 4'hF;
            flg_o[ofd_pkg::FLG_C] = s9[8];
            flg_o[ofd_pkg::FLG_DC] = h5[4];
            flg_o[ofd_pkg::FLG_OV] = (a_i[7] == b[7]) && (s9[7] != a_i[7]);
         end
         ofd_pkg::OP_AND: res_o = a_i & w_i;
         ofd_pkg::OP_IOR: res_o = a_i | w_i;
         ofd_pkg::OP_XOR: res_o = a_i ^ w_i;
         ofd_pkg::OP_COM: res_o = ~a_i;
         ofd_pkg::OP_MOVWF: res_o = w_i;
         ofd_pkg::OP_CLR: res_o = 8'h00;
         ofd_pkg::OP_SET: res_o = 8'hFF;
         ofd_pkg::OP_BIT: begin
            // whole byte passes, one bit changed
            case (bop_i)
               2'b00: res_o[bnum_i] = 1'b1; // RULE17
               2'b01: res_o[bnum_i] = 1'b0; // RULE17
               default: res_o[bnum_i] = ~a_i[bnum_i]; // RULE9
            endcase
         end
         default: res_o = a_i;
      endcase
      if (op_i inside {ofd_pkg::OP_AND, ofd_pkg::OP_IOR, ofd_pkg::OP_XOR,
                       ofd_pkg::OP_COM, ofd_pkg::OP_CLR}) begin
         fmask_o[ofd_pkg::FLG_Z] = 1'b1;
      end
      flg_o[ofd_pkg::FLG_Z] = (res_o == 8'h00);
   end
endmodule

/* File: verilog/ofd_core.sv */
// How it works
// RULE1: file operand is a full 8-bit address
// RULE2: peripheral operand reaches only 32 locations
// RULE3: pointer bit set increments table pointer after
// RULE4: byte-select bit picks low or high latch
// RULE5: d zero to working reg, one to file
// RULE6: s zero writes both, one file only
// RULE7: don't-care opcode bits are ignored
// RULE8: source sends unused opcode bits as zero
// RULE9: bit field selects one bit in byte
// RULE10: global irq mask is state reg bit four
// RULE11: 16-bit table pointer and split latch
// RULE12: reserved opcodes must not be issued
// RULE13: flag register write, then flag updates apply
// RULE14: reading pc low copies pc high to latch
// RULE15: writing pc low loads pc high from latch
// RULE16: pc low rmw loads high from latch
// RULE17: bit ops rewrite whole addressed byte
// RULE18: hardware flag updates land in first phase
// RULE19: special registers use normal file addressing
// RULE20: four phases; unused phases do nothing
//
// The Wishbone interface to the registers and the address map were decided locally.
`timescale 1ns/10ps
module ofd_core (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [7:0] hw_evt_i,
   output logic [1:0] phase_o,
   output logic busy_o
);
   ofd_pkg::ofd_phase_t ph_r, ph_nxt;
   ofd_pkg::ofd_dec_t dec_r, dec_nxt, dcur;
   logic pend_r, pend_nxt, ex_r, ex_nxt;
   logic [15:0] pir_r, pir_nxt, tbp_r, tbp_nxt, tbl_r, tbl_nxt;
   logic [7:0] opa_r, opa_nxt, res_r, res_nxt, w_r, w_nxt;
   logic [7:0] aluf_r, aluf_nxt, cpust_r, cpust_nxt;
   logic [7:0] iflag_r, iflag_nxt, evt_r, evt_nxt;
   logic [7:0] pcl_r, pcl_nxt, pch_r, pch_nxt, pc_high_holding_latch_r, pc_high_holding_latch_nxt;
   logic [3:0] flg_r, flg_nxt, fm_r, fm_nxt;
   logic [15:0] pc_inc;
   logic [7:0] mem_ra, mem_rd, srcv, alu_res;
   logic [3:0] alu_flg, alu_fm;
   logic mem_we, wb_req, wb_wr, ack_r, ack_nxt;
   logic [31:0] dat_r, dat_nxt;

   // decode of the waiting word, bus request qualifiers
   assign dcur = ofd_pkg::ofd_decode(pir_r);
   assign wb_req = wb_cyc_i & wb_stb_i & ~ack_r;
   assign wb_wr = wb_req & wb_we_i;
   assign pc_inc = 16'({pch_r, pcl_r} + 16'h0001);

   // operand address is issued in the decode phase
   assign mem_ra = (ph_r == ofd_pkg::Q1) ? dcur.src : dec_r.src;
   assign mem_we = (ph_r == ofd_pkg::Q4) & ex_r & dec_r.wr_f
                 & ~ofd_pkg::ofd_is_sfr(dec_r.dst); // RULE19

   ofd_fmem u_fmem (
      .clk_i(clk_i),
      .ce_i(ce_i),
      .we_i(mem_we),
      .waddr_i(dec_r.dst),
      .wdata_i(res_r),
      .raddr_i(mem_ra),
      .rdata_o(mem_rd)
   );

   ofd_alu u_alu (
      .op_i(dec_r.op),
      .a_i(opa_r),
      .w_i(w_r),
      .bnum_i(dec_r.bnum),
      .bop_i(dec_r.bop),
      .res_o(alu_res),
      .flg_o(alu_flg),
      .fmask_o(alu_fm)
   );

   // operand source mux, special registers by file address
   always_comb begin
      case (dec_r.src)
         ofd_pkg::SFR_PCL: srcv = pcl_r;
         ofd_pkg::SFR_PC_HIGH_HOLDING_LATCH: srcv = pc_high_holding_latch_r;
         ofd_pkg::SFR_ALUF: srcv = aluf_r;
         ofd_pkg::SFR_CPUST: srcv = cpust_r; // RULE10
         ofd_pkg::SFR_IFLAG: srcv = iflag_r;
         ofd_pkg::SFR_WORKING_REGISTER: srcv = w_r;
         ofd_pkg::SFR_TBPL: srcv = tbp_r[7:0];
         ofd_pkg::SFR_TBPH: srcv = tbp_r[15:8];
         default: srcv = mem_rd; // RULE19
      endcase
      if (dec_r.op == ofd_pkg::OP_TLRD) begin
         srcv = dec_r.hi ? tbl_r[15:8] : tbl_r[7:0]; // RULE4
      end
   end

   // next state of the execution pipeline and registers
   always_comb begin
      ph_nxt = ph_r;
      dec_nxt = dec_r;
      pend_nxt = pend_r;
      ex_nxt = ex_r;
      pir_nxt = pir_r;
      tbp_nxt = tbp_r;
      tbl_nxt = tbl_r;
      opa_nxt = opa_r;
      res_nxt = res_r;
      w_nxt = w_r;
      aluf_nxt = aluf_r;
      cpust_nxt = cpust_r;
      iflag_nxt = iflag_r;
      evt_nxt = evt_r | hw_evt_i;
      pcl_nxt = pcl_r;
      pch_nxt = pch_r;
      pc_high_holding_latch_nxt = pc_high_holding_latch_r;
      flg_nxt = flg_r;
      fm_nxt = fm_r;
      // bus writes, lowest priority
      if (wb_wr) begin
         case (wb_adr_i)
            ofd_pkg::BA_INSTR: begin
               if (!pend_r && (wb_sel_i[1:0] == 2'b11)) begin
                  pend_nxt = 1'b1;
                  pir_nxt = wb_dat_i[15:0];
               end
            end
            ofd_pkg::BA_WORKING_REGISTER: begin
               if (wb_sel_i[0]) begin
                  w_nxt = wb_dat_i[7:0];
               end
            end
            ofd_pkg::BA_TBPTR: begin
               if (wb_sel_i[0]) begin
                  tbp_nxt[7:0] = wb_dat_i[7:0];
               end
               if (wb_sel_i[1]) begin
                  tbp_nxt[15:8] = wb_dat_i[15:8];
               end
            end
            default: ;
         endcase
      end
      // phase sequencer
      case (ph_r)
         ofd_pkg::Q1: ph_nxt = ofd_pkg::Q2; // RULE20
         ofd_pkg::Q2: ph_nxt = ofd_pkg::Q3;
         ofd_pkg::Q3: ph_nxt = ofd_pkg::Q4;
         default: ph_nxt = ofd_pkg::Q1;
      endcase
      case (ph_r)
         ofd_pkg::Q1: begin
            // hardware flag events land before any read
            iflag_nxt = iflag_r | evt_r | hw_evt_i; // RULE18
            evt_nxt = 8'h00;
            ex_nxt = pend_r;
            if (pend_r) begin
               dec_nxt = dcur;
               pend_nxt = 1'b0;
            end
         end
         ofd_pkg::Q2: begin
            if (ex_r) begin
               opa_nxt = srcv;
               // only a true read of pc low copies; writes and rmw keep the latch
               if ((dec_r.src == ofd_pkg::SFR_PCL)
                     && !(dec_r.op inside {ofd_pkg::OP_NOP, ofd_pkg::OP_TLRD, ofd_pkg::OP_MOVWF,
                                           ofd_pkg::OP_CLR, ofd_pkg::OP_SET})
                     && !(dec_r.wr_f && (dec_r.dst == ofd_pkg::SFR_PCL))) begin
                  pc_high_holding_latch_nxt = pch_r; // RULE14
               end
            end
         end
         ofd_pkg::Q3: begin
            if (ex_r) begin
               res_nxt = alu_res;
               flg_nxt = alu_flg;
               fm_nxt = alu_fm;
            end
         end
         default: begin
            if (ex_r) begin
               pcl_nxt = pc_inc[7:0];
               pch_nxt = pc_inc[15:8];
               if (dec_r.wr_w) begin
                  w_nxt = res_r; // RULE5
               end
               if (dec_r.tlw) begin
                  if (dec_r.hi) begin
                     tbl_nxt[15:8] = res_r; // RULE11
                  end else begin
                     tbl_nxt[7:0] = res_r; // RULE4
                  end
               end
               if (dec_r.wr_f) begin
                  case (dec_r.dst)
                     ofd_pkg::SFR_PCL: begin
                        pcl_nxt = res_r; // RULE15
                        pch_nxt = pc_high_holding_latch_r; // RULE16
                     end
                     ofd_pkg::SFR_PC_HIGH_HOLDING_LATCH: pc_high_holding_latch_nxt = res_r;
                     ofd_pkg::SFR_ALUF: aluf_nxt = res_r;
                     ofd_pkg::SFR_CPUST: cpust_nxt = res_r; // RULE10
                     ofd_pkg::SFR_IFLAG: iflag_nxt = res_r;
                     ofd_pkg::SFR_WORKING_REGISTER: w_nxt = res_r; // RULE6
                     ofd_pkg::SFR_TBPL: tbp_nxt[7:0] = res_r;
                     ofd_pkg::SFR_TBPH: tbp_nxt[15:8] = res_r;
                     default: ;
                  endcase
               end
               // flag updates override the stored byte
               for (int i = 0; i < 4; i++) begin
                  if (fm_r[i]) begin
                     aluf_nxt[i] = flg_r[i]; // RULE13
                  end
               end
               if (dec_r.inc) begin
                  tbp_nxt = 16'(tbp_nxt + 16'h0001); // RULE3
               end
            end
         end
      endcase
   end

   // pipeline and register flops
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ph_r <= ofd_pkg::Q1;
         dec_r <= '0;
         pend_r <= 1'b0;
         ex_r <= 1'b0;
         pir_r <= ofd_pkg::WORD_RST;
         tbp_r <= ofd_pkg::WORD_RST;
         tbl_r <= ofd_pkg::WORD_RST;
         opa_r <= ofd_pkg::BYTE_RST;
         res_r <= ofd_pkg::BYTE_RST;
         w_r <= ofd_pkg::BYTE_RST;
         aluf_r <= ofd_pkg::BYTE_RST;
         cpust_r <= ofd_pkg::CPUST_RST;
         iflag_r <= ofd_pkg::BYTE_RST;
         evt_r <= ofd_pkg::BYTE_RST;
         pcl_r <= ofd_pkg::BYTE_RST;
         pch_r <= ofd_pkg::BYTE_RST;
         pc_high_holding_latch_r <= ofd_pkg::BYTE_RST;
         flg_r <= 4'h0;
         fm_r <= 4'h0;
      end else if (ce_i) begin
         ph_r <= ph_nxt;
         dec_r <= dec_nxt;
         pend_r <= pend_nxt;
         ex_r <= ex_nxt;
         pir_r <= pir_nxt;
         tbp_r <= tbp_nxt;
         tbl_r <= tbl_nxt;
         opa_r <= opa_nxt;
         res_r <= res_nxt;
         w_r <= w_nxt;
         aluf_r <= aluf_nxt;
         cpust_r <= cpust_nxt;
         iflag_r <= iflag_nxt;
         evt_r <= evt_nxt;
         pcl_r <= pcl_nxt;
         pch_r <= pch_nxt;
         pc_high_holding_latch_r <= pc_high_holding_latch_nxt;
         flg_r <= flg_nxt;
         fm_r <= fm_nxt;
      end
   end

   // bus answer: one-cycle ack, read data latched with it
   always_comb begin
      ack_nxt = wb_req;
      dat_nxt = 32'h0000_0000;
      if (wb_req && !wb_we_i) begin
         case (wb_adr_i)
            ofd_pkg::BA_INSTR: dat_nxt = {14'h0000, ex_r, pend_r, pir_r};
            ofd_pkg::BA_WORKING_REGISTER: dat_nxt = {24'h000000, w_r};
            ofd_pkg::BA_ALUF: dat_nxt = {24'h000000, aluf_r};
            ofd_pkg::BA_PC: dat_nxt = {16'h0000, pch_r, pcl_r};
            ofd_pkg::BA_PC_HIGH_HOLDING_LATCH: dat_nxt = {24'h000000, pc_high_holding_latch_r};
            ofd_pkg::BA_TBPTR: dat_nxt = {16'h0000, tbp_r};
            ofd_pkg::BA_TABLE_LATCH: dat_nxt = {16'h0000, tbl_r};
            ofd_pkg::BA_CPUST: dat_nxt = {24'h000000, cpust_r};
            ofd_pkg::BA_IFLAG: dat_nxt = {24'h000000, iflag_r};
            default: dat_nxt = 32'h0000_0000;
         endcase
      end
   end

   // bus answer flops
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         dat_r <= 32'h0000_0000;
      end else if (ce_i) begin
         ack_r <= ack_nxt;
         dat_r <= dat_nxt;
      end
   end

   // outputs
   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;
   assign phase_o = ph_r;
   assign busy_o = pend_r | ex_r;
endmodule

/* File: tb/ofd_isrc.sv */
`timescale 1ns/10ps
// instruction source: hands words to the core as a tool would emit them
module ofd_isrc (
   input wire logic [15:0] raw_i,
   input wire logic keep_x_i,
   output logic [15:0] word_o
);
   logic [15:0] xmask;
   // latch moves carry one don't-care position, bit eight
   assign xmask = (raw_i[15:11] == 5'h14) ? 16'h0100 : 16'h0000;
   // unused positions go out as zero unless a test asks otherwise
   assign word_o = keep_x_i ? raw_i : (raw_i & ~xmask);
endmodule

/* File: tb/ofd_core_sva.sv */
`timescale 1ns/10ps
// port watcher for the decoder core
module ofd_core_sva (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [7:0] hw_evt_i,
   input wire logic [1:0] phase_o,
   input wire logic busy_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // request accepted by the slave
   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
   endsequence
   sequence s_instr_wr;
      s_take ##0 (wb_we_i && wb_adr_i == ofd_pkg::BA_INSTR && wb_sel_i[1:0] == 2'h3);
   endsequence
   sequence s_rd_at(logic [7:0] a);
      s_take ##0 (!wb_we_i && wb_adr_i == a);
   endsequence
   sequence s_last_phase;
      ce_i && phase_o == 2'h3;
   endsequence
   AST_PHASE_WRAP: assert property (s_last_phase |=> phase_o == 2'h0)
      else $error("phase did not wrap after the last step");
   AST_PHASE_STEP: assert property (!rst_i && ce_i && phase_o != 2'h3 |=> phase_o == $past(phase_o) + 2'h1)
      else $error("phase did not advance by one");
   AST_PHASE_HOLD: assert property (!ce_i |=> $stable(phase_o) && $stable(wb_ack_o))
      else $error("state moved with clock enable low");
   AST_ACK_ONE: assert property (s_take |=> wb_ack_o)
      else $error("no ack one cycle after request");
   AST_ACK_DROP: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
      else $error("read data not zero without ack");
   AST_UNMAPPED: assert property (s_rd_at(8'h24) |=> wb_ack_o && wb_dat_o == 32'h00000000)
      else $error("unmapped read not zero");
   AST_FLAG_WIDTH: assert property (s_rd_at(ofd_pkg::BA_ALUF) |=> wb_dat_o[31:8] == 24'h000000)
      else $error("flag register wider than a byte");
   AST_BUSY_SET: assert property (s_instr_wr |=> busy_o)
      else $error("busy not set after instruction write");
   AST_BUSY_END: assert property ($rose(busy_o) |-> ##[1:12] !busy_o)
      else $error("instruction did not retire in time");
endmodule

/* File: tb/tb_ofd_core.sv */
`timescale 1ns/10ps
// bench for the operand decoder core
module tb_ofd_core;
   logic clk_i = 1'h0;
   logic rst_i = 1'h1;
   logic ce_i = 1'h1;
   logic wb_cyc_i = 1'h0;
   logic wb_stb_i = 1'h0;
   logic wb_we_i = 1'h0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic [7:0] hw_evt_i = 8'h00;
   logic [1:0] phase_o;
   logic busy_o;
   logic [15:0] raw = 16'h0000;
   logic keep_x = 1'h0;
   logic [15:0] word;
   logic [31:0] rd;
   logic [31:0] held;
   logic [7:0] acc;
   logic [1:0] ph;
   int mismatches = 0;
   int n_compared = 0;

   // 25 MHz clock
   always #20 clk_i = ~clk_i;

   ofd_core ofd_core_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .hw_evt_i(hw_evt_i),
      .phase_o(phase_o), .busy_o(busy_o));
   ofd_isrc ofd_isrc_i (.raw_i(raw), .keep_x_i(keep_x), .word_o(word));

   // verdict and end of run
   task automatic conclude;
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   // one classic cycle, held until ack is sampled
   task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
         input logic [3:0] s);
      int i;
      @(posedge clk_i);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= s;
      for (i = 0; i < 20; i++) begin
         @(posedge clk_i);
         if (wb_ack_o === 1'h1) break;
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      if (i == 20) begin
         mismatches++;
         conclude();
      end
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      bus(1'h0, a, 32'h0, 4'hF);
      chk(rd, e);
   endtask

   task automatic wv(input logic [7:0] v);
      bus(1'h1, ofd_pkg::BA_WORKING_REGISTER, {24'h000000, v}, 4'h1);
   endtask

   // hand one word over, optionally raise events, wait for retire
   task automatic ex(input logic [15:0] r, input logic kx = 1'h0, input logic [7:0] ev = 8'h00);
      int i;
      raw <= r;
      keep_x <= kx;
      @(posedge clk_i);
      bus(1'h1, ofd_pkg::BA_INSTR, {16'h0000, word}, 4'h3);
      hw_evt_i <= ev;
      @(posedge clk_i);
      hw_evt_i <= 8'h00;
      for (i = 0; i < 30; i++) begin
         if (busy_o === 1'h0) break;
         @(posedge clk_i);
      end
      if (i == 30) begin
         mismatches++;
         conclude();
      end
   endtask

   // main sequence
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'h0;
      rc(ofd_pkg::BA_CPUST, 32'h10);
      wv(8'h5A);
      ex(16'h0140);
      ex(16'h0E40);
      rc(ofd_pkg::BA_WORKING_REGISTER, 32'hB4);
      rc(ofd_pkg::BA_ALUF, 32'h0A);
      ex(16'h0F40);
      ex(16'h6A40);
      rc(ofd_pkg::BA_WORKING_REGISTER, 32'h0E);
      // logic and arithmetic ops on file 0x40 (holds 0x0E), result to working reg
      wv(8'h30);
      ex(16'h0840);
      rc(ofd_pkg::BA_WORKING_REGISTER, 32'h3E);
      ex(16'h0C40);
      rc(ofd_pkg::BA_WORKING_REGISTER, 32'h30);
      ex(16'h0A40);
      rc(ofd_pkg::BA_WORKING_REGISTER, 32'h00);
      ex(16'h1240);
      rc(ofd_pkg::BA_WORKING_REGISTER, 32'hF1);
      ex(16'h1440);
      rc(ofd_pkg::BA_WORKING_REGISTER, 32'h0F);
      ex(16'h0640);
      rc(ofd_pkg::BA_WORKING_REGISTER, 32'h0D);
      ex(16'h0440);
      rc(ofd_pkg::BA_WORKING_REGISTER, 32'h01);
      rc(ofd_pkg::BA_ALUF, 32'h03);
      ex(16'h2A41);
      rc(ofd_pkg::BA_WORKING_REGISTER, 32'hFF);
      ex(16'h2941);
      rc(ofd_pkg::BA_WORKING_REGISTER, 32'hFF);
      ex(16'h6A41);
      rc(ofd_pkg::BA_WORKING_REGISTER, 32'h00);
      ex(16'h2904);
      rc(ofd_pkg::BA_ALUF, 32'h04);
      wv(8'hC3);
      ex(16'h01FF);
      wv(8'h00);
      ex(16'h6AFF);
      rc(ofd_pkg::BA_WORKING_REGISTER, 32'hC3);
      wv(8'h77);
      ex(16'h011F);
      wv(8'h88);
      ex(16'h013F);
      ex(16'h5F0A);
      rc(ofd_pkg::BA_WORKING_REGISTER, 32'h77);
      // set each bit in turn, whole byte read back
      ex(16'h2950);
      acc = 8'h00;
      for (int b = 0; b < 8; b++) begin
         ex({5'h10, b[2:0], 8'h50});
         acc[b] = 1'h1;
         ex(16'h6A50);
         rc(ofd_pkg::BA_WORKING_REGISTER, {24'h000000, acc});
      end
      ex(16'h3B50);
      ex(16'h8850);
      ex(16'h6A50);
      rc(ofd_pkg::BA_WORKING_REGISTER, 32'hF6);
      // low byte of pc through the holding latch
      wv(8'h12);
      ex(16'h0103);
      wv(8'h34);
      ex(16'h0102);
      rc(ofd_pkg::BA_PC, 32'h1234);
      wv(8'h56);
      ex(16'h0103);
      ex(16'h6A02);
      rc(ofd_pkg::BA_PC_HIGH_HOLDING_LATCH, 32'h12);
      rc(ofd_pkg::BA_WORKING_REGISTER, 32'h35);
      // rmw on pc low takes the high byte from a latch that differs from it
      wv(8'h56);
      ex(16'h0103);
      ex(16'h1502);
      rc(ofd_pkg::BA_PC_HIGH_HOLDING_LATCH, 32'h56);
      rc(ofd_pkg::BA_PC, 32'h5638);
      // table pointer wrap and latch bytes
      bus(1'h1, ofd_pkg::BA_TBPTR, 32'hFFFF, 4'h3);
      wv(8'hAB);
      ex(16'hA60A);
      wv(8'hCD);
      ex(16'hA40A);
      rc(ofd_pkg::BA_TABLE_LATCH, 32'hABCD);
      ex(16'hAC0A);
      rc(ofd_pkg::BA_TBPTR, 32'hFFFF);
      ex(16'hAD0A);
      rc(ofd_pkg::BA_TBPTR, 32'h0000);
      ex(16'hA260);
      ex(16'hA161, 1'h1);
      ex(16'h6A60);
      rc(ofd_pkg::BA_WORKING_REGISTER, 32'hAB);
      ex(16'h6A61);
      rc(ofd_pkg::BA_WORKING_REGISTER, 32'hCD);
      ex(16'h8C06);
      rc(ofd_pkg::BA_CPUST, 32'h00);
      ex(16'h8406);
      rc(ofd_pkg::BA_CPUST, 32'h10);
      // hardware events arriving around a bit operation
      ex(16'h8707, 1'h0, 8'h01);
      repeat (4) @(posedge clk_i);
      rc(ofd_pkg::BA_IFLAG, 32'h81);
      ex(16'h8807, 1'h0, 8'h02);
      repeat (4) @(posedge clk_i);
      rc(ofd_pkg::BA_IFLAG, 32'h82);
      // refused and unmapped accesses
      bus(1'h1, ofd_pkg::BA_INSTR, 32'h0140, 4'h1);
      chk({31'h0, busy_o}, 32'h0);
      bus(1'h0, ofd_pkg::BA_ALUF, 32'h0, 4'hF);
      held = rd;
      bus(1'h1, ofd_pkg::BA_ALUF, 32'hFF, 4'hF);
      rc(ofd_pkg::BA_ALUF, held);
      rc(8'h24, 32'h0);
      // clock enable low freezes the phase
      ce_i <= 1'h0;
      @(posedge clk_i);
      ph = phase_o;
      repeat (3) @(posedge clk_i);
      chk({30'h0, phase_o}, {30'h0, ph});
      ce_i <= 1'h1;
      conclude();
   end
endmodule

bind ofd_core ofd_core_sva ofd_core_sva_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .hw_evt_i(hw_evt_i), .phase_o(phase_o), .busy_o(busy_o));
